//--- design/vsp_pkg.sv
// Package: constants and types shared by both ends of the serial port link
package vsp_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam int unsigned BAUD_MIN = 9600;
  localparam int unsigned BAUD_MAX = 921600;
  // Cycles per bit, default rounded to nearest, limits truncated
  localparam int unsigned DIV_DEFAULT =
    (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
  localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
  localparam int unsigned DIV_MAX = CLK_HZ / BAUD_MIN;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(DIV_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(DIV_MIN);
  localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(DIV_MAX);
  localparam int DATA_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [15:0] TCP_PORT = 16'h1325;
  // AHB register offsets, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_TXD = 8'h0C;
  localparam logic [7:0] REG_RXD = 8'h10;
  // Handshake mode field
  localparam logic [1:0] HS_DISABLE = 2'h0;
  localparam logic [1:0] HS_RTS = 2'h1;
  localparam logic [1:0] HS_CTS = 2'h2;
  localparam logic [1:0] HS_RTSCTS = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    VSP_IDLE = 2'b00,
    VSP_BITS = 2'b01,
    VSP_DONE = 2'b11
  } vsp_ser_e;
endpackage

//--- design/vsp_if.sv
// Interface: the four-wire serial link with its enable line
`timescale 1ns/1ps
interface vsp_if;
  logic tgt_tx;
  logic tgt_rx;
  logic cts_o;
  logic cts_oe_n;
  logic cts_i;
  logic rts;
  logic link_en;
  // Undriven clear-to-send floats high through a pull-up
  assign cts_i = cts_oe_n ? 1'b1 : cts_o;
  modport ctrl (
    input tgt_tx,
    output tgt_rx,
    output cts_o,
    output cts_oe_n,
    input rts,
    input link_en
  );
  modport target (
    output tgt_tx,
    input tgt_rx,
    input cts_i,
    output rts,
    output link_en
  );
endinterface

//--- design/vsp_ctrl.sv
// Board-controller end: AHB-Lite registers, UART and handshake control
//
// Operation
// - Data passes only while enable asserted
// - Target tx to controller, controller to rx
// - Reset default 115200 8N1, no handshake
// - Baud configurable from 9600 to 921600
// - Drop clear-to-send when receive buffer full
// - Target halts sending while clear-to-send low
// - Target raises request-to-send when ready
// - Stop sending while request-to-send low
// - Byte in progress always completes
// - Flow input off ignores request-to-send
// - Mode disabled: float cts, ignore rts
// - Mode rts: drive cts, ignore rts
// - Mode cts: float cts, gate on rts
// - Mode rtscts: drive cts and gate
// - TCP session blocks the USB path
// - Target should drive request-to-send line
`timescale 1ns/1ps
module vsp_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  vsp_if.ctrl link
);
  import vsp_pkg::*;

  typedef struct packed {
    logic ap_val;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [1:0] hs_mode;
    logic tcp_on;
    logic [DIV_W-1:0] div;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [7:0] rx_buf;
    logic rx_full;
    logic rx_ovr;
    vsp_ser_e tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
    vsp_ser_e rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
  } vsp_ctrl_s;

  vsp_ctrl_s st_r;
  vsp_ctrl_s st_nxt;
  logic rx_in;
  logic drive_cts;
  logic gate_rts;

  assign rx_in = link.link_en ? link.tgt_tx : 1'b1;
  assign drive_cts = st_r.hs_mode[0];
  assign gate_rts = st_r.hs_mode[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign link.tgt_rx = st_r.tx_line;
  assign link.cts_o = ~st_r.rx_full;
  assign link.cts_oe_n = ~drive_cts;

  always_comb begin
    logic [DIV_W-1:0] wdiv;
    logic rd_rx;
    wdiv = DIV_RST;
    rd_rx = 1'b0;
    st_nxt = st_r;
    st_nxt.rdata = ZERO32;
    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    if (st_r.ap_val && st_r.ap_wr) begin
      case (st_r.ap_addr)
        REG_CTRL: begin
          st_nxt.hs_mode = hwdata[1:0];
          st_nxt.tcp_on = hwdata[2];
        end
        REG_BAUD: begin
          wdiv = hwdata[DIV_W-1:0];
          // Clamp on the full word so large values do not wrap low
          if (hwdata > 32'(DIV_HI)) begin
            st_nxt.div = DIV_HI;
          end else if (wdiv < DIV_LO) begin
            st_nxt.div = DIV_LO;
          end else begin
            st_nxt.div = wdiv;
          end
        end
        REG_TXD: begin
          if (!st_r.tx_full) begin
            st_nxt.tx_buf = hwdata[7:0];
            st_nxt.tx_full = 1'b1;
          end
        end
        REG_STAT: begin
          if (hwdata[3]) begin
            st_nxt.rx_ovr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    st_nxt.ap_val = hsel && hready && htrans == HTRANS_NONSEQ;
    st_nxt.ap_wr = hwrite;
    st_nxt.ap_addr = haddr[7:0];
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
      case (haddr[7:0])
        REG_CTRL: st_nxt.rdata = {29'h0, st_r.tcp_on, st_r.hs_mode};
        REG_BAUD: st_nxt.rdata = {20'h0, st_r.div};
        REG_STAT: st_nxt.rdata = {27'h0, link.rts, st_r.rx_ovr,
                                  st_r.rx_full, st_r.tx_st != VSP_IDLE,
                                  st_r.tx_full};
        REG_RXD: begin
          st_nxt.rdata = {24'h0, st_r.rx_buf};
          rd_rx = 1'b1;
        end
        default: st_nxt.rdata = ZERO32;
      endcase
    end
    if (rd_rx) begin
      st_nxt.rx_full = 1'b0;
    end
    // ----------------------------------------------------------------
    // Transmitter toward the target
    // ----------------------------------------------------------------
    case (st_r.tx_st)
      VSP_IDLE: begin
        st_nxt.tx_line = 1'b1;
        // A new byte starts only when the gate allows
        if (st_r.tx_full && link.link_en && !st_r.tcp_on &&
            (!gate_rts || link.rts)) begin
          st_nxt.tx_sh = {1'b1, st_r.tx_buf, 1'b0};
          st_nxt.tx_full = 1'b0;
          st_nxt.tx_cnt = st_r.div;
          st_nxt.tx_bit = 4'h0;
          st_nxt.tx_line = 1'b0;
          st_nxt.tx_st = VSP_BITS;
        end
      end
      VSP_BITS: begin
        // No gate checked here: a byte under way always finishes
        if (st_r.tx_cnt == DIV_W'(1)) begin
          st_nxt.tx_cnt = st_r.div;
          if (st_r.tx_bit == LAST_BIT) begin
            st_nxt.tx_st = VSP_IDLE;
          end else begin
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            st_nxt.tx_line = st_r.tx_sh[st_r.tx_bit + 4'h1];
          end
        end else begin
          st_nxt.tx_cnt = st_r.tx_cnt - DIV_W'(1);
        end
      end
      default: st_nxt.tx_st = VSP_IDLE;
    endcase
    // ----------------------------------------------------------------
    // Receiver from the target, centre sampling
    // ----------------------------------------------------------------
    case (st_r.rx_st)
      VSP_IDLE: begin
        if (!rx_in) begin
          st_nxt.rx_cnt = {1'b0, st_r.div[DIV_W-1:1]};
          st_nxt.rx_bit = 4'h0;
          st_nxt.rx_st = VSP_BITS;
        end
      end
      VSP_BITS: begin
        if (st_r.rx_cnt == DIV_W'(1)) begin
          st_nxt.rx_cnt = st_r.div;
          if (st_r.rx_bit == 4'h0 && rx_in) begin
            st_nxt.rx_st = VSP_IDLE;
          end else if (st_r.rx_bit == LAST_BIT) begin
            st_nxt.rx_st = VSP_DONE;
          end else begin
            st_nxt.rx_bit = st_r.rx_bit + 4'h1;
            if (st_r.rx_bit != 4'h0) begin
              st_nxt.rx_sh = {rx_in, st_r.rx_sh[7:1]};
            end
          end
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt - DIV_W'(1);
        end
      end
      VSP_DONE: begin
        st_nxt.rx_st = VSP_IDLE;
        // Bytes are dropped while a TCP session owns the data path
        if (!st_r.tcp_on) begin
          if (st_r.rx_full && !rd_rx) begin
            st_nxt.rx_ovr = 1'b1;
          end else begin
            st_nxt.rx_buf = st_r.rx_sh;
            st_nxt.rx_full = 1'b1;
          end
        end
      end
      default: st_nxt.rx_st = VSP_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{ap_val: 1'b0, ap_wr: 1'b0, ap_addr: 8'h00, rdata: ZERO32,
                hs_mode: HS_DISABLE, tcp_on: 1'b0, div: DIV_RST,
                tx_buf: 8'h00, tx_full: 1'b0, rx_buf: 8'h00,
                rx_full: 1'b0, rx_ovr: 1'b0, tx_st: VSP_IDLE,
                tx_cnt: DIV_RST, tx_bit: 4'h0, tx_sh: 10'h3FF,
                tx_line: 1'b1, rx_st: VSP_IDLE, rx_cnt: DIV_RST,
                rx_bit: 4'h0, rx_sh: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

//--- design/vsp_target.sv
// Target end: byte UART with request-to-send and clear-to-send handling
`timescale 1ns/1ps
module vsp_target (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  input wire logic hs_en,
  input wire logic [vsp_pkg::DIV_W-1:0] div,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  vsp_if.target link
);
  import vsp_pkg::*;

  typedef struct packed {
    vsp_ser_e tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
    vsp_ser_e rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_buf;
    logic rx_full;
  } vsp_tgt_s;

  vsp_tgt_s st_r;
  vsp_tgt_s st_nxt;

  assign link.link_en = en;
  assign link.tgt_tx = st_r.tx_line;
  // Ready for more while the holding byte is free
  assign link.rts = ~st_r.rx_full;
  assign tx_ready = st_r.tx_st == VSP_IDLE && en &&
                    (!hs_en || link.cts_i);
  assign rx_valid = st_r.rx_full;
  assign rx_data = st_r.rx_buf;

  always_comb begin
    st_nxt = st_r;
    if (rx_ready && st_r.rx_full) begin
      st_nxt.rx_full = 1'b0;
    end
    case (st_r.tx_st)
      VSP_IDLE: begin
        st_nxt.tx_line = 1'b1;
        if (tx_valid && tx_ready) begin
          st_nxt.tx_sh = {1'b1, tx_data, 1'b0};
          st_nxt.tx_cnt = div;
          st_nxt.tx_bit = 4'h0;
          st_nxt.tx_line = 1'b0;
          st_nxt.tx_st = VSP_BITS;
        end
      end
      VSP_BITS: begin
        if (st_r.tx_cnt == DIV_W'(1)) begin
          st_nxt.tx_cnt = div;
          if (st_r.tx_bit == LAST_BIT) begin
            st_nxt.tx_st = VSP_IDLE;
          end else begin
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            st_nxt.tx_line = st_r.tx_sh[st_r.tx_bit + 4'h1];
          end
        end else begin
          st_nxt.tx_cnt = st_r.tx_cnt - DIV_W'(1);
        end
      end
      default: st_nxt.tx_st = VSP_IDLE;
    endcase
    case (st_r.rx_st)
      VSP_IDLE: begin
        if (!link.tgt_rx) begin
          st_nxt.rx_cnt = {1'b0, div[DIV_W-1:1]};
          st_nxt.rx_bit = 4'h0;
          st_nxt.rx_st = VSP_BITS;
        end
      end
      VSP_BITS: begin
        if (st_r.rx_cnt == DIV_W'(1)) begin
          st_nxt.rx_cnt = div;
          if (st_r.rx_bit == 4'h0 && link.tgt_rx) begin
            st_nxt.rx_st = VSP_IDLE;
          end else if (st_r.rx_bit == LAST_BIT) begin
            st_nxt.rx_st = VSP_DONE;
          end else begin
            st_nxt.rx_bit = st_r.rx_bit + 4'h1;
            if (st_r.rx_bit != 4'h0) begin
              st_nxt.rx_sh = {link.tgt_rx, st_r.rx_sh[7:1]};
            end
          end
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt - DIV_W'(1);
        end
      end
      VSP_DONE: begin
        st_nxt.rx_st = VSP_IDLE;
        // The one byte that may follow a dropped ready still lands
        st_nxt.rx_buf = st_r.rx_sh;
        st_nxt.rx_full = 1'b1;
      end
      default: st_nxt.rx_st = VSP_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{tx_st: VSP_IDLE, tx_cnt: DIV_RST, tx_bit: 4'h0,
                tx_sh: 10'h3FF, tx_line: 1'b1, rx_st: VSP_IDLE,
                rx_cnt: DIV_RST, rx_bit: 4'h0, rx_sh: 8'h00,
                rx_buf: 8'h00, rx_full: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

//--- verification/vsp_properties.sv
// Checker: timing relations on the serial link wires
`timescale 1ns/1ps
module vsp_properties
  import vsp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tgt_tx,
  input wire logic tgt_rx,
  input wire logic cts_o,
  input wire logic cts_oe_n,
  input wire logic cts_i,
  input wire logic rts,
  input wire logic link_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rxl_r;
  logic txl_r;
  logic [11:0] rxn_r;
  logic [11:0] txn_r;
  // ---
  // Run length of each line level, saturating as idle
  // ---
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxl_r <= 1'b1;
      txl_r <= 1'b1;
      rxn_r <= 12'hFFF;
      txn_r <= 12'hFFF;
    end else begin
      rxl_r <= tgt_rx;
      txl_r <= tgt_tx;
      rxn_r <= (tgt_rx != rxl_r) ? 12'h001 : rxn_r + 12'(rxn_r != 12'hFFF);
      txn_r <= (tgt_tx != txl_r) ? 12'h001 : txn_r + 12'(txn_r != 12'hFFF);
    end
  end
  AST_RX_BIT_LEN: assert property (
    tgt_rx != rxl_r |-> rxn_r >= DIV_LO)
    else $error("controller bit too short");
  AST_TX_BIT_LEN: assert property (
    tgt_tx != txl_r |-> txn_r >= DIV_LO)
    else $error("target bit too short");
  AST_RX_START_EN: assert property (
    $fell(tgt_rx) && rxn_r == 12'hFFF |-> $past(link_en))
    else $error("controller sent with link disabled");
  AST_TGT_HALT: assert property (
    $fell(tgt_tx) && txn_r == 12'hFFF |-> $past(cts_i) || $past(cts_i, 2))
    else $error("target started while clear-to-send low");
  AST_CTS_DROP_STOP: assert property (
    $fell(cts_o) |-> tgt_tx)
    else $error("clear-to-send dropped mid character");
  AST_RTS_DROP_STOP: assert property (
    $fell(rts) |-> tgt_rx)
    else $error("request-to-send dropped mid character");
  AST_CTS_FLOAT: assert property (
    cts_oe_n |-> cts_i)
    else $error("undriven clear-to-send not high");
  AST_CTS_DRIVE: assert property (
    !cts_oe_n |-> cts_i == cts_o)
    else $error("driven clear-to-send mismatch");
  cover property ($fell(cts_o));
  cover property ($fell(rts));
  cover property ($fell(tgt_rx) && rxn_r == 12'hFFF);
endmodule

//--- verification/testbench.sv
// Testbench: both link ends, register traffic and serial byte checks
`timescale 1ns/1ps
module testbench;
  import vsp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = ZERO32;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = ZERO32;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic en = 1'b1;
  logic [DIV_W-1:0] div = DIV_RST;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready;
  logic rx_valid;
  logic rx_ready = 1'b1;
  logic [7:0] rx_data;
  logic [31:0] q;
  logic [7:0] b;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 6;
  logic [7:0] got_q[$];
  vsp_if link_if();
  always #20 hclk = ~hclk;
  vsp_ctrl vsp_ctrl_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link_if.ctrl));
  vsp_target vsp_target_inst(.hclk(hclk), .hresetn(hresetn), .en(en),
    .hs_en(1'b1), .div(div), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .link(link_if.target));
  vsp_properties vsp_properties_inst(.hclk(hclk), .hresetn(hresetn),
    .tgt_tx(link_if.tgt_tx), .tgt_rx(link_if.tgt_rx),
    .cts_o(link_if.cts_o), .cts_oe_n(link_if.cts_oe_n),
    .cts_i(link_if.cts_i), .rts(link_if.rts), .link_en(link_if.link_en));
  // ---
  // Model: bytes handed over at the target
  // ---
  always @(posedge hclk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_data);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic fr(input int n);
    repeat (n * 12 * int'(div)) @(posedge hclk);
  endtask
  task automatic tsend(input logic [7:0] v);
    tx_valid <= 1'b1;
    tx_data <= v;
    do @(posedge hclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task automatic tgt_chk(input logic [7:0] e);
    fr(1);
    chk(32'(got_q.size()), 32'h1);
    if (got_q.size() > 0) chk(32'(got_q.pop_front()), 32'(e));
  endtask
  task automatic done(input string s);
    $display("%0s done, mismatches %0d", s, fail_count);
  endtask
  initial begin
    #1ms;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, REG_CTRL, ZERO32);
    chk(q, ZERO32);
    chk(32'(hresp), ZERO32);
    ahb(1'b0, REG_BAUD, ZERO32);
    chk(q, 32'(DIV_RST));
    b = 8'($random(seed));
    ahb(1'b1, REG_TXD, 32'(b));
    tgt_chk(b);
    done("defaults");
    ahb(1'b1, REG_BAUD, ZERO32);
    ahb(1'b0, REG_BAUD, ZERO32);
    chk(q, 32'(DIV_LO));
    ahb(1'b1, REG_BAUD, 32'hFFFF);
    ahb(1'b0, REG_BAUD, ZERO32);
    chk(q, 32'(DIV_HI));
    ahb(1'b1, REG_BAUD, 32'h1000);
    ahb(1'b0, REG_BAUD, ZERO32);
    chk(q, 32'(DIV_HI));
    ahb(1'b1, REG_BAUD, 32'(DIV_LO));
    div <= DIV_LO;
    done("baud");
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, REG_CTRL, 32'(m));
      @(posedge hclk);
      chk(32'(link_if.cts_oe_n), 32'(m % 2 == 0));
      b = 8'($random(seed));
      tsend(b);
      fr(1);
      chk(32'(link_if.cts_i), 32'(m % 2 == 0));
      ahb(1'b0, REG_RXD, ZERO32);
      chk(q, 32'(b));
      rx_ready <= 1'b0;
      b = 8'($random(seed));
      ahb(1'b1, REG_TXD, 32'(b));
      fr(1);
      chk(32'(rx_data), 32'(b));
      ahb(1'b1, REG_TXD, 32'(b + 8'h5A));
      fr(1);
      ahb(1'b0, REG_STAT, ZERO32);
      chk(32'(q[0]), 32'(m / 2));
      rx_ready <= 1'b1;
      fr(1);
      if (m > 1) chk(32'(got_q[$]), 32'(8'(b + 8'h5A)));
      got_q.delete();
    end
    done("handshake");
    en <= 1'b0;
    b = 8'($random(seed));
    ahb(1'b1, REG_TXD, 32'(b));
    fr(1);
    ahb(1'b0, REG_STAT, ZERO32);
    chk(32'(q[0]), 32'h1);
    en <= 1'b1;
    tgt_chk(b);
    ahb(1'b1, REG_CTRL, 32'h4);
    b = 8'($random(seed));
    ahb(1'b1, REG_TXD, 32'(b));
    tsend(~b);
    fr(1);
    chk(32'(got_q.size()), 32'h0);
    ahb(1'b0, REG_STAT, ZERO32);
    chk(32'(q[2]), 32'h0);
    ahb(1'b1, REG_CTRL, ZERO32);
    tgt_chk(b);
    done("enable and session");
    report_and_stop();
  end
endmodule
